// ### inc/pid_process_controller_cfg.svh
// Timing, code and reset constants for the PID process controller.
`ifndef PID_PROCESS_CONTROLLER_CFG_SVH
`define PID_PROCESS_CONTROLLER_CFG_SVH

`define PID_CLK_PERIOD_NS    40
`define PID_SAMPLE_PERIOD_NS 1000000
`define PID_SAMPLE_CYCLES    (`PID_SAMPLE_PERIOD_NS / `PID_CLK_PERIOD_NS)
`define PID_TERM_COUNT       12
`define PID_FUNC_ENABLE      7'h0e
`define PID_FUNC_SWAP        7'h40
`define PID_FUNC_IRESET      7'h48
`define PID_MODE_DEV_REV     7'h0a
`define PID_MODE_DEV_FWD     7'h0b
`define PID_MODE_MEAS_REV    7'h14
`define PID_MODE_MEAS_FWD    7'h15
`define PID_MODE_COMDEV_REV  7'h32
`define PID_MODE_COMDEV_FWD  7'h33
`define PID_MODE_COMMEAS_REV 7'h3c
`define PID_MODE_COMMEAS_FWD 7'h3d
`define PID_MODE_XDEV_REV    7'h6e
`define PID_MODE_XDEV_FWD    7'h6f
`define PID_MODE_XMEAS_REV   7'h78
`define PID_MODE_XMEAS_FWD   7'h79
`define PID_SP_SENTINEL      14'h270f
`define PID_PCT_FULL         1000
`define PID_DIV_5V_MV        5
`define PID_DIV_10V_MV       10
`define PID_DIV_20MA_UA      20
`define PID_MEAS_OFFSET_UA   4000
`define PID_DIV_4_20MA_UA    16
`define PID_P_SHIFT          4
`define PID_I_SHIFT          8
`define PID_D_SHIFT          4
`define PID_INTEG_LIMIT      256000
`define PID_RESET_FREQ       16'h0000
`define PID_RESET_INTEG      24'h000000
`define PID_RESET_ERR        12'h000

`endif

// ### inc/pid_process_controller_pkg.sv
// Types shared by the PID process controller and its users.
package pid_process_controller_pkg;

    typedef logic [6:0] func_code_t;

    typedef enum logic [1:0] {
        ACT_PI  = 2'h0,
        ACT_PD  = 2'h1,
        ACT_PID = 2'h2
    } action_t;

    typedef enum logic {
        ST_BYPASS = 1'b0,
        ST_RUN    = 1'b1
    } ctl_state_t;

    typedef struct packed {
        logic [15:0]        set_point_level;
        logic signed [15:0] deviation_level;
        logic [15:0]        measured_level;
    } analog_in_t;

    typedef struct packed {
        action_t    action;
        logic [7:0] prop_gain;
        logic [7:0] integ_gain;
        logic [7:0] deriv_gain;
    } gains_t;

    typedef struct packed {
        logic valid;
        logic use_measured;
        logic forward;
        logic always_on;
    } mode_info_t;

endpackage

// ### hdl/pid_process_controller.sv
// PID process controller that steers the output frequency of a motor drive.
`timescale 1ns/100ps
`include "pid_process_controller_cfg.svh"

// Contract
// - PID runs only while the enable input is asserted, except exempt modes.
// - With enable deasserted in a non-exempt mode, the ordinary frequency command passes straight through.
// - Modes 50,51,60,61,110,111,120,121 run PID regardless of the enable input.
// - Modes 20,21,120,121 form deviation as set point minus measured value.
// - Modes 10,11,110,111 use the external signed deviation channel directly.
// - Reverse polarity raises output for positive deviation, lowers for negative.
// - Forward polarity raises output for negative deviation, lowers for positive.
// - Mode code picks polarity; the swap input inverts that choice.
// - Integral reset input clears integral and derivative state while asserted.
// - PI operation outputs proportional plus integral term.
// - PD operation outputs proportional plus derivative term.
// - PID operation outputs proportional plus integral plus derivative terms.
// - Stored set point 9999 selects the set-point channel, else stored percent.
// - Set-point channel scales by 0-20mA, 0-5V or 0-10V per selection code.
// - Deviation channel scales by +-5V or +-10V per selection code.
// - Measured channel scales 4-20mA for selection 0, 0-5V for selection 1.
// - Enable, swap and reset follow terminals assigned function codes 14, 64, 72.
module pid_process_controller #(
    parameter int SAMPLE_CYCLES = `PID_SAMPLE_CYCLES
) (
    input  wire logic                                   sys_clk_in,
    input  wire logic                                   rst_n_in,
    input  wire logic [`PID_TERM_COUNT-1:0]             terminal_in,
    input  pid_process_controller_pkg::func_code_t      input_function_assign_in [`PID_TERM_COUNT],
    input  wire logic [6:0]                             pid_mode_code_in,
    input  wire logic [13:0]                            stored_set_point_in,
    input  wire logic [4:0]                             set_point_channel_range_select_in,
    input  wire logic [1:0]                             measured_channel_range_select_in,
    input  pid_process_controller_pkg::analog_in_t      analog_in,
    input  pid_process_controller_pkg::gains_t          gains_in,
    input  wire logic [15:0]                            freq_command_in,
    input  wire logic [15:0]                            freq_max_in,
    output logic [15:0]                                 output_freq_out,
    output logic                                        pid_active_out
);
    import pid_process_controller_pkg::*;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Limits a value to a range and returns it as a signed percent in 0.1 % steps.
    function automatic logic signed [11:0] clamp_pct(input int v, input int lo, input int hi);
        int r;
        r = (v < lo) ? lo : ((v > hi) ? hi : v);
        return 12'(r);
    endfunction

    // Reports whether a terminal carries the given function code and is on.
    function automatic logic func_level(input logic [`PID_TERM_COUNT-1:0] lv,
                                        input func_code_t a [`PID_TERM_COUNT],
                                        input func_code_t code);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < `PID_TERM_COUNT; k++) begin
            hit = hit | (lv[k] & (a[k] == code));
        end
        return hit;
    endfunction

    // Decodes the mode code into source, polarity and enable exemption.
    function automatic mode_info_t decode_mode(input logic [6:0] m);
        mode_info_t r;
        r = '{valid: 1'b1, use_measured: 1'b0, forward: 1'b0, always_on: 1'b0};
        if (m == `PID_MODE_DEV_REV || m == `PID_MODE_DEV_FWD) begin
            r.forward = m[0];
        end else if (m == `PID_MODE_MEAS_REV || m == `PID_MODE_MEAS_FWD) begin
            r.use_measured = 1'b1;
            r.forward      = m[0];
        end else if (m == `PID_MODE_COMDEV_REV || m == `PID_MODE_COMDEV_FWD ||
                     m == `PID_MODE_XDEV_REV || m == `PID_MODE_XDEV_FWD) begin
            r.forward   = m[0];
            r.always_on = 1'b1;
        end else if (m == `PID_MODE_COMMEAS_REV || m == `PID_MODE_COMMEAS_FWD ||
                     m == `PID_MODE_XMEAS_REV || m == `PID_MODE_XMEAS_FWD) begin
            r.use_measured = 1'b1;
            r.forward      = m[0];
            r.always_on    = 1'b1;
        end else begin
            r.valid = 1'b0;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Terminal synchronisers and function routing
    // ------------------------------------------------------------------
    logic [`PID_TERM_COUNT-1:0] term_meta;
    logic [`PID_TERM_COUNT-1:0] term_sync;
    logic                       enable_lvl;
    logic                       swap_lvl;
    logic                       ireset_lvl;

    // Two flops per terminal; only the second stage feeds the routing.
    always_ff @(posedge sys_clk_in) begin
        term_meta <= terminal_in;
        term_sync <= term_meta;
    end

    // Each function follows whichever terminal is assigned its code.
    assign enable_lvl = func_level(term_sync, input_function_assign_in, `PID_FUNC_ENABLE);
    assign swap_lvl   = func_level(term_sync, input_function_assign_in, `PID_FUNC_SWAP);
    assign ireset_lvl = func_level(term_sync, input_function_assign_in, `PID_FUNC_IRESET);

    // ------------------------------------------------------------------
    // Input scaling and deviation
    // ------------------------------------------------------------------
    mode_info_t               info;
    logic                     pid_active;
    logic                     eff_forward;
    logic                     sp_ma;
    logic                     sp_5v;
    logic                     dev_5v;
    logic signed [11:0]       sp_chan_pct;
    logic signed [11:0]       sp_pct;
    logic signed [11:0]       pv_pct;
    logic signed [11:0]       ext_dev_pct;
    logic signed [11:0]       deviation;
    logic signed [11:0]       ctl_err;

    // Range codes decide the full scale of the set-point and deviation channels.
    assign sp_ma  = set_point_channel_range_select_in inside {5'h06, 5'h07, 5'h10, 5'h11};
    assign sp_5v  = set_point_channel_range_select_in inside
                    {5'h01, 5'h03, 5'h05, 5'h0b, 5'h0d, 5'h0f};
    assign dev_5v = set_point_channel_range_select_in inside
                    {5'h02, 5'h03, 5'h05, 5'h07, 5'h0c, 5'h0d, 5'h0f, 5'h11};

    // Channels are converted to 0.1 % steps, then the deviation is chosen.
    always_comb begin
        info        = decode_mode(pid_mode_code_in);
        eff_forward = info.forward ^ swap_lvl;
        pid_active  = info.valid & (info.always_on | enable_lvl);
        if (sp_ma) begin
            sp_chan_pct = clamp_pct(int'(analog_in.set_point_level) / `PID_DIV_20MA_UA,
                                    0, `PID_PCT_FULL);
        end else if (sp_5v) begin
            sp_chan_pct = clamp_pct(int'(analog_in.set_point_level) / `PID_DIV_5V_MV,
                                    0, `PID_PCT_FULL);
        end else begin
            sp_chan_pct = clamp_pct(int'(analog_in.set_point_level) / `PID_DIV_10V_MV,
                                    0, `PID_PCT_FULL);
        end
        if (stored_set_point_in == `PID_SP_SENTINEL) begin
            sp_pct = sp_chan_pct;
        end else begin
            sp_pct = clamp_pct(int'(stored_set_point_in), 0, `PID_PCT_FULL);
        end
        if (measured_channel_range_select_in == 2'h0) begin
            pv_pct = clamp_pct((int'(analog_in.measured_level) - `PID_MEAS_OFFSET_UA) /
                               `PID_DIV_4_20MA_UA, 0, `PID_PCT_FULL);
        end else begin
            pv_pct = clamp_pct(int'(analog_in.measured_level) / `PID_DIV_5V_MV,
                               0, `PID_PCT_FULL);
        end
        if (dev_5v) begin
            ext_dev_pct = clamp_pct(int'(analog_in.deviation_level) / `PID_DIV_5V_MV,
                                    -`PID_PCT_FULL, `PID_PCT_FULL);
        end else begin
            ext_dev_pct = clamp_pct(int'(analog_in.deviation_level) / `PID_DIV_10V_MV,
                                    -`PID_PCT_FULL, `PID_PCT_FULL);
        end
        if (info.use_measured) begin
            deviation = sp_pct - pv_pct;
        end else begin
            deviation = ext_dev_pct;
        end
        ctl_err = eff_forward ? -deviation : deviation;
    end

    // ------------------------------------------------------------------
    // Sample tick divider
    // ------------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic        tick;

    // Free-running divider gives a one-cycle enable per sample period.
    always_comb begin
        tick          = (tick_cnt == 32'(SAMPLE_CYCLES - 1));
        next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
        if (!rst_n_in) begin
            next_tick_cnt = 32'h0;
        end
    end

    // Registers the divider count.
    always_ff @(posedge sys_clk_in) begin
        tick_cnt <= next_tick_cnt;
    end

    // ------------------------------------------------------------------
    // PID terms, state machine and output
    // ------------------------------------------------------------------
    ctl_state_t         state;
    ctl_state_t         next_state;
    logic signed [23:0] integ;
    logic signed [23:0] next_integ;
    logic signed [11:0] err_prev;
    logic signed [11:0] next_err_prev;
    logic signed [11:0] mv;
    logic signed [11:0] next_mv;
    logic [15:0]        next_freq;
    int                 p_term;
    int                 i_term;
    int                 d_term;
    int                 i_sum;

    // Terms are formed from the corrected error; the sum sets the manipulated variable.
    always_comb begin
        p_term = (int'(ctl_err) * int'(gains_in.prop_gain)) >>> `PID_P_SHIFT;
        i_sum  = int'(integ) + int'(ctl_err) * int'(gains_in.integ_gain);
        i_sum  = (i_sum > `PID_INTEG_LIMIT) ? `PID_INTEG_LIMIT :
                 ((i_sum < -`PID_INTEG_LIMIT) ? -`PID_INTEG_LIMIT : i_sum);
        i_term = i_sum >>> `PID_I_SHIFT;
        d_term = ((int'(ctl_err) - int'(err_prev)) * int'(gains_in.deriv_gain)) >>> `PID_D_SHIFT;
        next_state    = pid_active ? ST_RUN : ST_BYPASS;
        next_integ    = integ;
        next_err_prev = err_prev;
        next_mv       = mv;
        if (state == ST_BYPASS || ireset_lvl) begin
            next_integ    = `PID_RESET_INTEG;
            next_err_prev = `PID_RESET_ERR;
        end else if (tick) begin
            next_integ    = 24'(i_sum);
            next_err_prev = ctl_err;
            case (gains_in.action)
                ACT_PI: begin
                    next_mv = clamp_pct(p_term + i_term, 0, `PID_PCT_FULL);
                end
                ACT_PD: begin
                    next_mv = clamp_pct(p_term + d_term, 0, `PID_PCT_FULL);
                end
                default: begin
                    next_mv = clamp_pct(p_term + i_term + d_term, 0, `PID_PCT_FULL);
                end
            endcase
        end
        if (state == ST_RUN) begin
            next_freq = 16'((32'(mv) * 32'(freq_max_in)) / `PID_PCT_FULL);
        end else begin
            next_freq = freq_command_in;
        end
        if (!rst_n_in) begin
            next_state    = ST_BYPASS;
            next_integ    = `PID_RESET_INTEG;
            next_err_prev = `PID_RESET_ERR;
            next_mv       = `PID_RESET_ERR;
            next_freq     = `PID_RESET_FREQ;
        end
    end

    // Registers the controller state and output.
    always_ff @(posedge sys_clk_in) begin
        state           <= next_state;
        integ           <= next_integ;
        err_prev        <= next_err_prev;
        mv              <= next_mv;
        output_freq_out <= next_freq;
    end

    assign pid_active_out = (state == ST_RUN);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_bypass_two;
        !pid_active ##1 !pid_active;
    endsequence

    property p_bypass_pass;
        s_bypass_two |=> (output_freq_out == $past(freq_command_in));
    endproperty
    a_bypass_pass: assert property (p_bypass_pass) else $error("bypass did not pass command");

    property p_enable_gate;
        (!info.always_on && !enable_lvl) |=> !pid_active_out;
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("PID ran without enable");

    property p_exempt_on;
        (info.valid && info.always_on) |=> pid_active_out;
    endproperty
    a_exempt_on: assert property (p_exempt_on) else $error("exempt mode not running");

    property p_meas_dev;
        info.use_measured |-> (deviation == sp_pct - pv_pct);
    endproperty
    a_meas_dev: assert property (p_meas_dev) else $error("measured deviation wrong");

    property p_polarity;
        ctl_err == ((info.forward ^ swap_lvl) ? -deviation : deviation);
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity choice wrong");

    sequence s_reset_tick;
        ireset_lvl && state == ST_RUN;
    endsequence

    property p_ireset;
        s_reset_tick |=> (integ == 24'h0 && err_prev == 12'h0);
    endproperty
    a_ireset: assert property (p_ireset) else $error("integral not cleared");

    property p_tick_only;
        (!tick && !ireset_lvl && state == ST_RUN && pid_active) |=> $stable(integ);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("integral moved off tick");

    property p_sentinel;
        (stored_set_point_in == `PID_SP_SENTINEL) |-> (sp_pct == sp_chan_pct);
    endproperty
    a_sentinel: assert property (p_sentinel) else $error("set point source wrong");

    property p_mv_range;
        (mv >= 12'sh000) && (mv <= 12'sh3e8);
    endproperty
    a_mv_range: assert property (p_mv_range) else $error("manipulated variable out of range");

endmodule

// ### tb/pid_drive_partner.sv
// Process detector and drive command model that feeds the PID process controller.
`timescale 1ns/100ps
module pid_drive_partner (
    input  wire logic                              sys_clk_in,
    input  pid_process_controller_pkg::analog_in_t target_in,
    input  wire logic [15:0]                       command_in,
    output pid_process_controller_pkg::analog_in_t analog_out,
    output logic [15:0]                            freq_command_out
);
    import pid_process_controller_pkg::*;

    // Detector levels and the ordinary command are taken up on the rising edge by a
    // non-blocking update, so a bench change at the falling edge never races this model.
    always_ff @(posedge sys_clk_in) begin
        analog_out       <= target_in;
        freq_command_out <= command_in;
    end
endmodule

// ### tb/test_pid_process_controller.sv
// Self-checking testbench for the PID process controller.
`timescale 1ns/100ps
`include "pid_process_controller_cfg.svh"
module test_pid_process_controller;
    import pid_process_controller_pkg::*;

    // -------------------------------------------------------------------
    // Signals and scenario table
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [6:0]         mode;
        logic               swap;
        logic [13:0]        sp_store;
        logic [4:0]         rsel;
        logic [15:0]        sp_lvl;
        logic signed [15:0] dev;
        logic [1:0]         msel;
        logic [15:0]        meas;
        logic [15:0]        expect_out;
    } row_t;

    logic                        sys_clk;
    logic                        rst_n;
    logic [`PID_TERM_COUNT-1:0]  term;
    func_code_t                  fassign [`PID_TERM_COUNT];
    logic [6:0]                  mode;
    logic [13:0]                 sp_store;
    logic [4:0]                  rsel;
    logic [1:0]                  msel;
    analog_in_t                  target;
    analog_in_t                  analog;
    gains_t                      gains;
    logic [15:0]                 cmd;
    logic [15:0]                 fcmd;
    logic [15:0]                 out_freq;
    logic                        active;
    logic [15:0]                 t1;
    logic [15:0]                 t2;
    int                          errors;
    int                          n_checks;

    // Output is twice the manipulated variable in 0.1 percent, since full scale is 2000.
    row_t rows [12] = '{
        '{7'h78, 1'b0, 14'h258, 5'h00, 16'h0000, 16'h0000, 2'h1, 16'h03e8, 16'h0320},
        '{7'h78, 1'b0, `PID_SP_SENTINEL, 5'h00, 16'h1f40, 16'h0000, 2'h1, 16'h03e8, 16'h04b0},
        '{7'h78, 1'b0, `PID_SP_SENTINEL, 5'h06, 16'h3e80, 16'h0000, 2'h0, 16'h2ee0, 16'h0258},
        '{7'h78, 1'b0, `PID_SP_SENTINEL, 5'h01, 16'h0fa0, 16'h0000, 2'h1, 16'h03e8, 16'h04b0},
        '{7'h79, 1'b0, 14'h0c8, 5'h00, 16'h0000, 16'h0000, 2'h1, 16'h0bb8, 16'h0320},
        '{7'h78, 1'b1, 14'h0c8, 5'h00, 16'h0000, 16'h0000, 2'h1, 16'h0bb8, 16'h0320},
        '{7'h79, 1'b1, 14'h0c8, 5'h00, 16'h0000, 16'h0000, 2'h1, 16'h0bb8, 16'h0000},
        '{7'h6e, 1'b0, 14'h000, 5'h00, 16'h0000, 16'h1388, 2'h1, 16'h0000, 16'h03e8},
        '{7'h6e, 1'b0, 14'h000, 5'h02, 16'h0000, 16'h09c4, 2'h1, 16'h0000, 16'h03e8},
        '{7'h6e, 1'b0, 14'h000, 5'h00, 16'h0000, 16'hf060, 2'h1, 16'h0000, 16'h0000},
        '{7'h6f, 1'b0, 14'h000, 5'h00, 16'h0000, 16'hf060, 2'h1, 16'h0000, 16'h0320},
        '{7'h6f, 1'b0, 14'h000, 5'h03, 16'h0000, 16'h05dc, 2'h1, 16'h0000, 16'h0000}
    };
    logic [6:0] codes [13] = '{7'h0a, 7'h0b, 7'h14, 7'h15, 7'h32, 7'h33, 7'h3c,
                               7'h3d, 7'h6e, 7'h6f, 7'h78, 7'h79, 7'h00};

    pid_drive_partner partner (
        .sys_clk_in       (sys_clk),
        .target_in        (target),
        .command_in       (cmd),
        .analog_out       (analog),
        .freq_command_out (fcmd)
    );

    pid_process_controller #(.SAMPLE_CYCLES(8)) dut (
        .sys_clk_in                        (sys_clk),
        .rst_n_in                          (rst_n),
        .terminal_in                       (term),
        .input_function_assign_in          (fassign),
        .pid_mode_code_in                  (mode),
        .stored_set_point_in               (sp_store),
        .set_point_channel_range_select_in (rsel),
        .measured_channel_range_select_in  (msel),
        .analog_in                         (analog),
        .gains_in                          (gains),
        .freq_command_in                   (fcmd),
        .freq_max_in                       (16'h07d0),
        .output_freq_out                   (out_freq),
        .pid_active_out                    (active)
    );

    // -------------------------------------------------------------------
    // Clock, tasks and watchdog
    // -------------------------------------------------------------------
    // The 25 MHz clock toggles every half period.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // A short reset aligns the sample tick, so the first tick lands near the eighth edge.
    task automatic restart();
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
    endtask

    // Runs the deviation channel at 50 percent and takes the output after one tick and again after two ticks.
    task automatic act_run(input action_t act, input logic [7:0] kp, ki, kd);
        gains = '{act, kp, ki, kd};
        mode = 7'h6e;
        rsel = 5'h00;
        target = '{16'h0000, 16'h1388, 16'h0000};
        restart();
        cyc(12);
        t1 = out_freq;
        cyc(8);
        t2 = out_freq;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The whole run needs about four hundred cycles, so a hang is cut off well beyond that.
    initial begin
        repeat (6000) @(posedge sys_clk);
        errors++;
        complete_run();
    end

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        term = '0;
        foreach (fassign[i]) fassign[i] = 7'h00;
        fassign[3] = `PID_FUNC_ENABLE;
        fassign[7] = `PID_FUNC_SWAP;
        fassign[11] = `PID_FUNC_IRESET;
        mode = 7'h0a;
        sp_store = 14'h000;
        rsel = 5'h00;
        msel = 2'h1;
        target = '{16'h0000, 16'h1388, 16'h0000};
        gains = '{ACT_PI, 8'h10, 8'h00, 8'h00};
        cmd = 16'h0bb8;
        cyc(5);
        check(out_freq, 16'h0000, "reset output");
        check({15'h0, active}, 16'h0001 ^ 16'h0001, "reset active");
        rst_n = 1'b1;
        // Enable off: only the exempt codes run the controller.
        foreach (codes[i]) begin
            mode = codes[i];
            cyc(3);
            check({15'h0, active}, {15'h0, codes[i] inside {7'h32, 7'h33, 7'h3c, 7'h3d,
                  7'h6e, 7'h6f, 7'h78, 7'h79}}, "active by code");
        end
        mode = 7'h0a;
        cyc(3);
        check(out_freq, 16'h0bb8, "bypass output");
        term[3] = 1'b1;
        cyc(2);
        check({15'h0, active}, 16'h0000, "enable early");
        cyc(2);
        check({15'h0, active}, 16'h0001, "enable seen");
        cyc(20);
        check(out_freq, 16'h03e8, "enabled output");
        term[7] = 1'b1;
        cyc(20);
        check(out_freq, 16'h0000, "swapped output");
        term[3] = 1'b0;
        term[7] = 1'b0;
        cmd = 16'h0123;
        cyc(6);
        check(out_freq, 16'h0123, "bypass follows");
        check({15'h0, active}, 16'h0000, "disabled");
        // Source, scaling and polarity table with proportional action alone.
        foreach (rows[i]) begin
            mode = rows[i].mode;
            term[7] = rows[i].swap;
            sp_store = rows[i].sp_store;
            rsel = rows[i].rsel;
            msel = rows[i].msel;
            target = '{rows[i].sp_lvl, rows[i].dev, rows[i].meas};
            restart();
            cyc(12);
            check(out_freq, rows[i].expect_out, "table output");
        end
        term[7] = 1'b0;
        act_run(ACT_PI, 8'h10, 8'h00, 8'hff);
        check(t1, 16'h03e8, "pi ignores derivative");
        act_run(ACT_PD, 8'h10, 8'hff, 8'h10);
        check(t1, 16'h07d0, "pd first tick");
        check(t2, 16'h03e8, "pd steady");
        act_run(ACT_PID, 8'h10, 8'h10, 8'h10);
        check(t1, 16'h07d0, "pid first tick");
        check({15'h0, t2 > 16'h03e8}, 16'h0001, "pid keeps integral");
        act_run(ACT_PI, 8'h00, 8'hff, 8'h00);
        check(t1, 16'h03e4, "integral first tick");
        check({15'h0, t2 > t1}, 16'h0001, "integral grows");
        // Integral reset held through start-up keeps the state cleared.
        term[11] = 1'b1;
        restart();
        cyc(28);
        check(out_freq, 16'h0000, "integral held clear");
        term[11] = 1'b0;
        cyc(8);
        check(out_freq, 16'h03e4, "integral restarts");
        complete_run();
    end
endmodule
